// file: sbcspi_pkg.sv
// sbcspi_pkg: shared addresses, field positions, codes and states of the serial command port.
// assumes: 16-bit frames, 7-bit register address, access bit, data byte in bits 15..8.
package sbcspi_pkg;

	// ==========================================================
	// frame layout
	localparam int         FRAME_BITS     = 16;
	localparam logic [4:0] FRAME_CNT_FULL = 5'h10;
	localparam logic [4:0] FRAME_CNT_NONE = 5'h00;
	localparam logic [4:0] FRAME_CNT_ADDR = 5'h07;
	localparam int         ACCESS_BIT     = 7;

	// ==========================================================
	// register addresses
	localparam logic [6:0] ADDR_MODE_CTRL  = 7'h01;
	localparam logic [6:0] ADDR_HW_CTRL    = 7'h02;
	localparam logic [6:0] ADDR_WATCHDOG_CONTROL_REG    = 7'h03;
	localparam logic [6:0] ADDR_BUS_CTRL1  = 7'h04;
	localparam logic [6:0] ADDR_WK_CTRL2   = 7'h07;
	localparam logic [6:0] ADDR_TIMER1     = 7'h0c;
	localparam logic [6:0] ADDR_TIMER2     = 7'h0d;
	localparam logic [6:0] ADDR_CTRL_LAST  = 7'h1e;
	localparam logic [6:0] ADDR_SUP2_STAT  = 7'h40;
	localparam logic [6:0] ADDR_SUP1_STAT  = 7'h41;
	localparam logic [6:0] ADDR_THERMAL_STATUS = 7'h42;
	localparam logic [6:0] ADDR_DEVICE_STATUS   = 7'h43;
	localparam logic [6:0] ADDR_BUS_STAT   = 7'h44;
	localparam logic [6:0] ADDR_WK_STAT1   = 7'h46;
	localparam logic [6:0] ADDR_WK_STAT2   = 7'h47;
	localparam logic [6:0] ADDR_WK_LVL     = 7'h48;
	localparam logic [6:0] ADDR_HS_OC_STAT = 7'h54;
	localparam logic [6:0] ADDR_SWITCH_OPEN_LOAD_STATUS = 7'h55;
	localparam logic [6:0] ADDR_FAM_PROD   = 7'h7e;

	// ==========================================================
	// field positions and reset values
	localparam int         MODE_FIELD_LO  = 6;
	localparam int         CMD_FAIL_BIT   = 1;
	localparam int         WAKE_MEASURE_ENABLE_BIT    = 5;
	localparam logic [7:0] WK12_EN_MASK   = 8'h03;
	localparam int         TMR_PER_LO     = 0;
	localparam int         TMR_ON_LO      = 3;
	localparam logic [7:0] CTRL_RESET     = 8'h00;
	localparam logic [7:0] STAT_RESET     = 8'h00;

	// ==========================================================
	// mode field codes of the mode control register
	localparam logic [1:0] MF_NORMAL  = 2'h0;
	localparam logic [1:0] MF_SLEEP   = 2'h1;
	localparam logic [1:0] MF_STOP    = 2'h2;
	localparam logic [1:0] MF_SOFTRST = 2'h3;

	typedef enum logic [2:0] {
		MODE_INIT    = 3'h0,
		MODE_NORMAL  = 3'h1,
		MODE_STOP    = 3'h3,
		MODE_SLEEP   = 3'h2,
		MODE_RESTART = 3'h6,
		MODE_SOFTRST = 3'h7
	} sbcspi_mode_t;

	typedef enum logic [1:0] {
		FR_IDLE   = 2'h0,
		FR_ACTIVE = 2'h1,
		FR_EVAL   = 2'h3
	} sbcspi_frame_t;

endpackage : sbcspi_pkg

// file: sbcspi_sync.sv
// sbcspi_sync: two-flop synchroniser for levels entering the ref_clk domain.
// assumes: each bit is a slow level or toggle; bits are not related to each other.
`timescale 1ns/1ps
module sbcspi_sync #(
	parameter int               WIDTH     = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	// clock and reset
	input  wire logic             ref_clk,
	input  wire logic             reset_n,
	// level in and out
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_r;

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			meta_r   <= RESET_VAL;
			sync_out <= RESET_VAL;
		end else begin
			meta_r   <= async_in;
			sync_out <= meta_r;
		end
	end

endmodule : sbcspi_sync

// file: sbcspi_link.sv
// sbcspi_link: pin-facing logic on the serial clock.
// assumes: err_bit and force_high are held steady by ref_clk logic during a frame; resp_word's data byte loads mid-frame, before its bits shift out.
`timescale 1ns/1ps
module sbcspi_link (
	// serial pins
	input  wire logic        spi_clk,
	input  wire logic        reset_n,
	input  wire logic        chip_select_low,
	input  wire logic        sdi,
	output logic             sdo_out,
	output logic             sdo_oe_n,
	// ref_clk side
	input  wire logic [15:0] resp_word,
	input  wire logic        err_bit,
	input  wire logic        force_high,
	output logic             sdi_bit_r,
	output logic             fall_tog_r
);

	logic [4:0] rise_cnt_r;

	// ==========================================================
	// input sampling
	// no frame reset here: the ref side counts toggles itself, so nothing is lost at frame end
	always_ff @(negedge spi_clk or negedge reset_n) begin
		if (!reset_n) begin
			sdi_bit_r  <= 1'b0;
			fall_tog_r <= 1'b0;
		end else begin
			sdi_bit_r  <= sdi;
			fall_tog_r <= ~fall_tog_r;
		end
	end

	// ==========================================================
	// output shifting
	always_ff @(posedge spi_clk or posedge chip_select_low) begin
		if (chip_select_low) begin
			rise_cnt_r <= 5'h00;
		end else if (rise_cnt_r != sbcspi_pkg::FRAME_CNT_FULL) begin
			rise_cnt_r <= rise_cnt_r + 5'h01;
		end
	end

	always_comb begin
		if (force_high) begin
			sdo_out = 1'b1;
		end else if (rise_cnt_r == 5'h00) begin
			sdo_out = err_bit;
		end else begin
			sdo_out = resp_word[4'(rise_cnt_r - 5'h01)];
		end
	end

	// released as soon as select goes high, without waiting for a clock
	assign sdo_oe_n = chip_select_low;

endmodule : sbcspi_link

// file: sbcspi_cmd_port.sv
// sbcspi_cmd_port: serial command port of the system basis chip, register decode and checks.
// assumes: mode state machine, reset output and status sources live outside and share ref_clk.
// How it works
// - 16-bit frame, acted on after select high
// - sample on falling, shift on rising
// - output released when select rises
// - bad command ignored, sticky fail flag
// - stop to sleep fails, goes restart
// - stop/sleep from init fails, goes normal
// - odd watchdog parity fails, ignored
// - stop mode accepts few commands only
// - stop entry with wakes pulses interrupt
// - stop to normal changes mode only
// - sleep without wake source goes restart
// - sleep with measurement wake goes restart
// - timer on-time not below period fails
// - all-zero or all-one frame fails
// - clock count not 0/16 flags error
// - frame overlapping reset output flags error
// - output high while reset output low
// - address, access bit, data byte layout
// - restart ignores commands, flags stay set
// - read shows old contents, write later
// - response carries status summary byte
// - control and status address ranges
`timescale 1ns/1ps
module sbcspi_cmd_port #(
	parameter logic [7:0] FAMILY_PRODUCT_ID = 8'h5a // arbitrary value
) (
	// clock and reset
	input  wire logic       ref_clk,
	input  wire logic       reset_n,
	// serial link
	input  wire logic       spi_clk,
	input  wire logic       chip_select_low,
	input  wire logic       sdi,
	output logic            sdo_out,
	output logic            sdo_oe_n,
	// device state
	input  wire logic [2:0] sbc_mode,
	input  wire logic       reset_output_low,
	input  wire logic [7:0] wake_level_status,
	// status sources
	input  wire logic       stat_set_valid,
	input  wire logic [6:0] stat_set_addr,
	input  wire logic [7:0] stat_set_bits,
	// control writes
	output logic            ctrl_wr_valid_r,
	output logic [6:0]      ctrl_wr_addr_r,
	output logic [7:0]      ctrl_wr_data_r,
	output logic            wd_trigger_r,
	// mode requests and events
	output logic            mode_req_valid_r,
	output logic [2:0]      mode_req_r,
	output logic            int_pulse_r,
	output logic            cmd_fail_r,
	output logic            frame_err_r
);

	import sbcspi_pkg::*;

	// ==========================================================
	// helpers
	function automatic logic [2:0] mode_of(input logic [1:0] field);
		case (field)
			MF_NORMAL: mode_of = 3'(MODE_NORMAL);
			MF_SLEEP:  mode_of = 3'(MODE_SLEEP);
			MF_STOP:   mode_of = 3'(MODE_STOP);
			default:   mode_of = 3'(MODE_SOFTRST);
		endcase
	endfunction : mode_of

	function automatic logic clearable(input logic [6:0] a);
		clearable = a[6] && (a != ADDR_WK_LVL) && (a != ADDR_FAM_PROD);
	endfunction : clearable

	// ==========================================================
	// crossing and pins
	logic        csn_s, tog_s, sclk_s;
	logic        sdi_bit, fall_tog;
	logic [15:0] resp_word;
	logic        force_high_r;

	sbcspi_sync #(.WIDTH(3), .RESET_VAL(3'h4)) u_sync (
		.ref_clk  (ref_clk),
		.reset_n  (reset_n),
		.async_in ({chip_select_low, fall_tog, spi_clk}),
		.sync_out ({csn_s, tog_s, sclk_s})
	);

	sbcspi_link u_link (
		.spi_clk         (spi_clk),
		.reset_n         (reset_n),
		.chip_select_low (chip_select_low),
		.sdi             (sdi),
		.sdo_out         (sdo_out),
		.sdo_oe_n        (sdo_oe_n),
		.resp_word       (resp_word),
		.err_bit         (frame_err_r),
		.force_high      (force_high_r),
		.sdi_bit_r       (sdi_bit),
		.fall_tog_r      (fall_tog)
	);

	// ==========================================================
	// frame tracking
	sbcspi_frame_t frame_r;
	logic          tog_d_r;
	logic [15:0]   rx_r;
	logic [4:0]    cnt_r;
	logic          clk_err_r, rst_hit_r;
	logic [7:0]    resp_data_r, resp_stat_r;
	logic [7:0]    stat_field, rd_byte;
	logic          fall_evt, is_eval, err_now, exec_w;

	assign fall_evt  = tog_s ^ tog_d_r;
	assign is_eval   = (frame_r == FR_EVAL);
	assign resp_word = {resp_data_r, resp_stat_r};

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			frame_r <= FR_IDLE;
		end else begin
			case (frame_r)
				FR_IDLE:   if (!csn_s) frame_r <= FR_ACTIVE;
				FR_ACTIVE: if (csn_s) frame_r <= FR_EVAL;
				FR_EVAL:   frame_r <= FR_IDLE;
				default:   frame_r <= FR_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			tog_d_r     <= 1'b0;
			rx_r        <= 16'h0000;
			cnt_r       <= 5'h00;
			resp_data_r <= 8'h00;
			resp_stat_r <= 8'h00;
		end else begin
			tog_d_r <= tog_s;
			if (frame_r == FR_IDLE && !csn_s) begin
				cnt_r       <= 5'h00;
				resp_data_r <= 8'h00;
				resp_stat_r <= stat_field; // frozen so the summary cannot tear mid-frame
			end else if (frame_r == FR_ACTIVE && fall_evt) begin
				rx_r <= {sdi_bit, rx_r[15:1]}; // lsb first
				if (cnt_r != 5'h1f) cnt_r <= cnt_r + 5'h01;
				if (cnt_r == FRAME_CNT_ADDR) resp_data_r <= rd_byte;
			end
		end
	end

	// clock level at both select edges, reset output low anywhere in the frame
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			clk_err_r <= 1'b0;
			rst_hit_r <= 1'b0;
		end else if (frame_r == FR_IDLE) begin
			clk_err_r <= !csn_s && sclk_s;
			rst_hit_r <= !csn_s && reset_output_low;
		end else if (frame_r == FR_ACTIVE) begin
			clk_err_r <= clk_err_r || (csn_s && sclk_s);
			rst_hit_r <= rst_hit_r || reset_output_low;
		end
	end

	assign err_now = ((cnt_r != FRAME_CNT_NONE) && (cnt_r != FRAME_CNT_FULL))
		|| clk_err_r || rst_hit_r || reset_output_low;
	// zero clocks raises no error flag and executes nothing
	assign exec_w = is_eval && (cnt_r == FRAME_CNT_FULL) && !err_now
		&& (sbc_mode != MODE_RESTART);

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			frame_err_r  <= 1'b0;
			force_high_r <= 1'b0;
		end else begin
			force_high_r <= reset_output_low;
			if (is_eval) frame_err_r <= err_now;
		end
	end

	// ==========================================================
	// register storage
	logic [7:0] ctrl_mem [0:31];
	logic [7:0] stat_mem [0:63];
	logic [7:0] stat_nxt [0:63];

	always_comb begin
		stat_field[0] = |stat_mem[ADDR_SUP1_STAT[5:0]];
		stat_field[1] = |stat_mem[ADDR_THERMAL_STATUS[5:0]];
		stat_field[2] = |stat_mem[ADDR_DEVICE_STATUS[5:0]];
		stat_field[3] = |stat_mem[ADDR_BUS_STAT[5:0]];
		stat_field[4] = |(stat_mem[ADDR_WK_STAT1[5:0]] | stat_mem[ADDR_WK_STAT2[5:0]]);
		stat_field[5] = |stat_mem[ADDR_SUP2_STAT[5:0]];
		stat_field[6] = |stat_mem[ADDR_HS_OC_STAT[5:0]];
		stat_field[7] = |stat_mem[ADDR_SWITCH_OPEN_LOAD_STATUS[5:0]];
	end

	// address bits are the first seven sampled, read before any write lands
	always_comb begin
		logic [6:0] a;
		a = rx_r[15:9];
		if (a == ADDR_WK_LVL) begin
			rd_byte = wake_level_status;
		end else if (a == ADDR_FAM_PROD) begin
			rd_byte = FAMILY_PRODUCT_ID;
		end else if (a[6]) begin
			rd_byte = stat_mem[a[5:0]];
		end else if (a <= ADDR_CTRL_LAST) begin
			rd_byte = ctrl_mem[a[4:0]];
		end else begin
			rd_byte = 8'h00;
		end
	end

	// ==========================================================
	// command decode
	logic [6:0] c_addr;
	logic [7:0] c_data;
	logic       fail, do_wr, do_clr, mv, irq, wdt;
	logic [7:0] wdat;
	logic [2:0] mreq;
	logic [1:0] mfield;
	logic       no_wake, meas_only;

	assign c_addr = rx_r[6:0];
	assign c_data = rx_r[15:8];
	assign mfield = c_data[MODE_FIELD_LO +: 2];
	assign no_wake = (ctrl_mem[ADDR_BUS_CTRL1[4:0]] == 8'h00)
		&& (ctrl_mem[ADDR_WK_CTRL2[4:0]] == 8'h00);
	assign meas_only = ctrl_mem[ADDR_HW_CTRL[4:0]][WAKE_MEASURE_ENABLE_BIT]
		&& (ctrl_mem[ADDR_BUS_CTRL1[4:0]] == 8'h00)
		&& (ctrl_mem[ADDR_WK_CTRL2[4:0]] != 8'h00)
		&& ((ctrl_mem[ADDR_WK_CTRL2[4:0]] & ~WK12_EN_MASK) == 8'h00);

	always_comb begin
		fail   = 1'b0;
		do_wr  = 1'b0;
		do_clr = 1'b0;
		mv     = 1'b0;
		irq    = 1'b0;
		wdt    = 1'b0;
		wdat   = c_data;
		mreq   = sbc_mode;
		if (rx_r == 16'h0000 || rx_r == 16'hffff) begin
			fail = 1'b1;
		end else if (rx_r[ACCESS_BIT] && clearable(c_addr)) begin
			do_clr = 1'b1;
		end else if (rx_r[ACCESS_BIT] && c_addr <= ADDR_CTRL_LAST) begin
			if (c_addr == ADDR_MODE_CTRL) begin
				case (sbc_mode)
					MODE_STOP: begin
						if (mfield == MF_NORMAL) begin
							mv    = 1'b1;
							mreq  = 3'(MODE_NORMAL);
							do_wr = 1'b1;
							wdat  = {mfield, ctrl_mem[ADDR_MODE_CTRL[4:0]][5:0]};
							fail  = (c_data[5:0] != ctrl_mem[ADDR_MODE_CTRL[4:0]][5:0]);
						end else if (mfield == MF_SOFTRST) begin
							mv   = 1'b1;
							mreq = 3'(MODE_SOFTRST);
						end else if (mfield == MF_SLEEP) begin
							fail = 1'b1;
							mv   = 1'b1;
							mreq = 3'(MODE_RESTART);
						end else begin
							fail = 1'b1;
						end
					end
					MODE_INIT: begin
						do_wr = 1'b1;
						mv    = 1'b1;
						if (mfield == MF_STOP || mfield == MF_SLEEP) begin
							fail = 1'b1;
							mreq = 3'(MODE_NORMAL);
							wdat = {MF_NORMAL, c_data[5:0]};
						end else begin
							mreq = mode_of(mfield);
						end
					end
					default: begin
						do_wr = 1'b1;
						mv    = 1'b1;
						mreq  = mode_of(mfield);
						if (mfield == MF_SLEEP && (no_wake || meas_only)) begin
							fail = 1'b1;
							mreq = 3'(MODE_RESTART);
						end
						if (mfield == MF_STOP && stat_field[4]) irq = 1'b1;
					end
				endcase
			end else if (c_addr == ADDR_WATCHDOG_CONTROL_REG) begin
				if (^c_data) begin
					fail = 1'b1;
				end else begin
					wdt   = 1'b1;
					do_wr = 1'b1;
				end
			end else if (sbc_mode == MODE_STOP) begin
				fail = 1'b1;
			end else if ((c_addr == ADDR_TIMER1 || c_addr == ADDR_TIMER2)
				&& (c_data[TMR_ON_LO +: 3] >= c_data[TMR_PER_LO +: 3])) begin
				fail = 1'b1;
			end else begin
				do_wr = 1'b1;
			end
		end
	end

	// ==========================================================
	// register updates
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < 32; i++) ctrl_mem[i] <= CTRL_RESET;
		end else if (exec_w && do_wr && !fail) begin
			ctrl_mem[c_addr[4:0]] <= wdat;
		end else if (exec_w && do_wr && mv) begin
			ctrl_mem[c_addr[4:0]] <= wdat;
		end
	end

	// hardware set is applied after the host clear, so a same-cycle event survives
	always_comb begin
		for (int i = 0; i < 64; i++) begin
			stat_nxt[i] = stat_mem[i];
			if (exec_w && do_clr && c_addr[5:0] == 6'(i)) stat_nxt[i] = STAT_RESET;
			if (stat_set_valid && stat_set_addr[6] && stat_set_addr[5:0] == 6'(i))
				stat_nxt[i] = stat_nxt[i] | stat_set_bits;
		end
		if (exec_w && fail) stat_nxt[ADDR_DEVICE_STATUS[5:0]][CMD_FAIL_BIT] = 1'b1;
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < 64; i++) stat_mem[i] <= STAT_RESET;
		end else begin
			stat_mem <= stat_nxt;
		end
	end

	// ==========================================================
	// output strobes
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_wr_valid_r  <= 1'b0;
			ctrl_wr_addr_r   <= 7'h00;
			ctrl_wr_data_r   <= 8'h00;
			wd_trigger_r     <= 1'b0;
			mode_req_valid_r <= 1'b0;
			mode_req_r       <= 3'(MODE_INIT);
			int_pulse_r      <= 1'b0;
			cmd_fail_r       <= 1'b0;
		end else begin
			ctrl_wr_valid_r  <= exec_w && do_wr && (!fail || mv);
			wd_trigger_r     <= exec_w && wdt;
			mode_req_valid_r <= exec_w && mv;
			int_pulse_r      <= exec_w && irq;
			cmd_fail_r       <= stat_nxt[ADDR_DEVICE_STATUS[5:0]][CMD_FAIL_BIT];
			if (exec_w) begin
				ctrl_wr_addr_r <= c_addr;
				ctrl_wr_data_r <= wdat;
				mode_req_r     <= mreq;
			end
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	a_frame_whole: assert property (ctrl_wr_valid_r |-> $past(is_eval)
		&& $past(cnt_r) == FRAME_CNT_FULL) else $error("write from a short frame");
	a_fail_sticky: assert property (cmd_fail_r && !(exec_w && do_clr
		&& c_addr == ADDR_DEVICE_STATUS) |=> cmd_fail_r) else $error("fail flag dropped");
	a_stop_sleep: assert property (exec_w && sbc_mode == MODE_STOP && do_clr == 1'b0
		&& c_addr == ADDR_MODE_CTRL && rx_r[ACCESS_BIT] && mfield == MF_SLEEP
		|=> mode_req_valid_r && mode_req_r == 3'(MODE_RESTART) && cmd_fail_r)
		else $error("stop to sleep not refused");
	a_init_normal: assert property (exec_w && sbc_mode == MODE_INIT && mv
		&& (mfield == MF_STOP || mfield == MF_SLEEP)
		|=> mode_req_r == 3'(MODE_NORMAL) && cmd_fail_r) else $error("init request");
	a_wd_parity: assert property (exec_w && c_addr == ADDR_WATCHDOG_CONTROL_REG && rx_r[ACCESS_BIT]
		&& ^c_data |=> !wd_trigger_r && !ctrl_wr_valid_r && cmd_fail_r)
		else $error("odd parity accepted");
	a_stop_irq: assert property (exec_w && sbc_mode == MODE_NORMAL && mv
		&& mfield == MF_STOP && stat_field[4] |=> int_pulse_r ##1 !int_pulse_r)
		else $error("no wake pulse on stop");
	a_timer_cfg: assert property (exec_w && sbc_mode != MODE_STOP && rx_r[ACCESS_BIT]
		&& c_addr == ADDR_TIMER1 && c_data[5:3] >= c_data[2:0]
		|=> !ctrl_wr_valid_r && cmd_fail_r) else $error("bad timer accepted");
	a_stuck_line: assert property (is_eval && cnt_r == FRAME_CNT_FULL
		&& (rx_r == 16'h0000 || rx_r == 16'hffff) && exec_w
		|=> !ctrl_wr_valid_r && cmd_fail_r) else $error("stuck line accepted");
	a_count_err: assert property (is_eval && cnt_r != FRAME_CNT_NONE
		&& cnt_r != FRAME_CNT_FULL |=> frame_err_r && !ctrl_wr_valid_r [*2])
		else $error("bad clock count not flagged");
	a_reset_high: assert property (reset_output_low |=> force_high_r)
		else $error("output not forced high");
	a_restart_quiet: assert property (is_eval && sbc_mode == MODE_RESTART
		|=> !ctrl_wr_valid_r && !mode_req_valid_r) else $error("restart executed");

endmodule : sbcspi_cmd_port

// file: sbcspi_host.sv
// sbcspi_host: serial bus master model that sends frames to the command port.
// assumes: link clock period 80 ns, clock idle low, clock stands still between frames.
`timescale 1ns/1ps
module sbcspi_host (
	// serial pins
	output logic      spi_clk,
	output logic      chip_select_low,
	output logic      sdi,
	input  wire logic sdo_out,
	input  wire logic sdo_oe_n
);
	// select rises a little late so the link's select-edge clear is always seen
	initial begin
		spi_clk = 1'b0;
		sdi = 1'b0;
		#1 chip_select_low = 1'b1;
	end

	// ==========================================================
	// frame: n clocks, lsb first, response sampled on falls
	task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] r,
		output logic e);
		r = '0;
		chip_select_low = 1'b0;
		#20 e = sdo_out;
		for (int k = 0; k < n; k++) begin
			spi_clk = 1'b1;
			sdi = w[k];
			#40 spi_clk = 1'b0;
			r[k] = sdo_out;
			#40;
		end
		#20 chip_select_low = 1'b1;
		// idle data line not left at last bit, so nothing leans on a stale value
		sdi = ~sdi;
		#60;
	endtask : xfer
endmodule : sbcspi_host

// file: testbench.sv
// testbench: frame-level tests of the serial command port.
// assumes: mode machine and status sources modelled here as plain stimulus.
`timescale 1ns/1ps
module testbench;
	logic        ref_clk, reset_n, spi_clk, chip_select_low, sdi, sdo_out, sdo_oe_n;
	logic [2:0]  sbc_mode, mode_req_r, mq;
	logic        reset_output_low, stat_set_valid;
	logic [7:0]  wake_level_status, stat_set_bits, ctrl_wr_data_r;
	logic [6:0]  stat_set_addr, ctrl_wr_addr_r;
	logic        ctrl_wr_valid_r, wd_trigger_r, mode_req_valid_r, int_pulse_r;
	logic        cmd_fail_r, frame_err_r, err;
	logic [15:0] rsp;
	logic [6:0]  sa [8] = '{7'h41, 7'h42, 7'h43, 7'h44, 7'h46, 7'h40, 7'h54, 7'h55};
	int          errors = 0, checks = 0, n_wr, n_wd, n_md, n_int;

	sbcspi_cmd_port dut_u (.ref_clk(ref_clk), .reset_n(reset_n), .spi_clk(spi_clk),
		.chip_select_low(chip_select_low), .sdi(sdi), .sdo_out(sdo_out), .sdo_oe_n(sdo_oe_n),
		.sbc_mode(sbc_mode), .reset_output_low(reset_output_low),
		.wake_level_status(wake_level_status), .stat_set_valid(stat_set_valid),
		.stat_set_addr(stat_set_addr), .stat_set_bits(stat_set_bits),
		.ctrl_wr_valid_r(ctrl_wr_valid_r), .ctrl_wr_addr_r(ctrl_wr_addr_r),
		.ctrl_wr_data_r(ctrl_wr_data_r), .wd_trigger_r(wd_trigger_r),
		.mode_req_valid_r(mode_req_valid_r), .mode_req_r(mode_req_r),
		.int_pulse_r(int_pulse_r), .cmd_fail_r(cmd_fail_r), .frame_err_r(frame_err_r));
	sbcspi_host host_u (.spi_clk(spi_clk), .chip_select_low(chip_select_low), .sdi(sdi),
		.sdo_out(sdo_out), .sdo_oe_n(sdo_oe_n));

	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	// pulses are one cycle wide, so count them rather than poll
	always @(posedge ref_clk) begin
		n_wr += ctrl_wr_valid_r;
		n_wd += wd_trigger_r;
		n_md += mode_req_valid_r;
		n_int += int_pulse_r;
	end

	// ==========================================================
	// helpers
	task automatic chk(input logic [15:0] g, input logic [15:0] e, input string m);
		checks++;
		if (g !== e) begin
			errors++;
			$display("[ERR] %0t %s got %h exp %h", $time, m, g, e);
		end
	endtask : chk
	task automatic fn(input logic [15:0] w, input int n);
		{n_wr, n_wd, n_md, n_int} = '0;
		host_u.xfer(w, n, rsp, err);
		repeat (20) @(posedge ref_clk);
		#1;
	endtask : fn
	task automatic fr(input logic [15:0] w);
		fn(w, 16);
	endtask : fr
	task automatic stat(input logic [6:0] a, input logic [7:0] b);
		stat_set_addr = a;
		stat_set_bits = b;
		stat_set_valid = 1'b1;
		@(posedge ref_clk);
		#1 stat_set_valid = 1'b0;
	endtask : stat
	task automatic fails(input logic [15:0] w, input logic f, input string m);
		fr(w);
		chk(cmd_fail_r, f, m);
		// the clear frame below rewrites the request, so keep it here
		mq = mode_req_r;
		fr(16'h00c3);
	endtask : fails
	task automatic finish_test;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : finish_test

	initial begin
		#300000;
		errors++;
		finish_test();
	end

	// ==========================================================
	// tests
	initial begin
		// reset starts high so its falling edge reaches every waiting process
		{reset_n, stat_set_valid, reset_output_low} = 3'b100;
		{stat_set_addr, stat_set_bits} = '0;
		sbc_mode = 3'h1;
		wake_level_status = 8'h3c;
		#1 reset_n = 1'b0;
		repeat (5) @(posedge ref_clk);
		#1 reset_n = 1'b1;
		repeat (4) @(posedge ref_clk);
		#1 chk(sdo_oe_n, 1, "oe idle");
		fr(16'ha584);
		chk({rsp[15:8], 1'b0, ctrl_wr_addr_r}, 16'h0004, "old");
		chk(ctrl_wr_data_r, 8'ha5, "wdata");
		fr(16'h0004);
		chk({rsp[15:8], 8'(n_wr)}, 16'ha500, "new");
		for (int i = 0; i < 8; i++) begin
			stat(sa[i], 8'h10);
			fr(16'h0002);
			chk(rsp[7:0], 8'h01 << i, "summary");
			fr({8'h00, 1'b1, sa[i]});
			chk(rsp[15:8], 8'h10, "rdclr");
		end
		fr(16'h00c8);
		fr(16'h00c8);
		chk(rsp, 16'h3c00, "lvl kept");
		fails(16'h0000, 1, "zeros");
		fails(16'hffff, 1, "ones");
		fails(16'h1b8c, 1, "timer eq");
		fails(16'h0a8c, 0, "timer ok");
		fails(16'h0183, 1, "odd par");
		fails(16'h0383, 0, "even par");
		fr(16'h0183);
		chk(n_wd, 0, "wd ignored");
		fr(16'h0043);
		chk(rsp[15:8], 8'h02, "fail bit");
		fr(16'h00c3);
		chk(cmd_fail_r, 0, "cleared");
		sbc_mode = 3'h0;
		fails(16'h8081, 1, "init stop");
		chk(mq, 3'h1, "to normal");
		fails(16'h4081, 1, "init sleep");
		sbc_mode = 3'h3;
		fails(16'h4081, 1, "stop sleep");
		chk(mq, 3'h6, "restart");
		fr(16'ha584);
		chk({cmd_fail_r, 8'(n_wr)}, 16'h0100, "stop wr");
		fr(16'h00c3);
		fails(16'h0181, 1, "stop norm");
		chk(mq, 3'h1, "mode only");
		fails(16'h8081, 1, "stop stop");
		fr(16'h0383);
		chk({cmd_fail_r, 8'(n_wd)}, 16'h0001, "stop wd");
		fr(16'hc081);
		chk({cmd_fail_r, 8'(n_md)}, 16'h0001, "stop soft");
		chk(mode_req_r, 3'h7, "soft req");
		sbc_mode = 3'h1;
		stat(7'h46, 8'h01);
		fr(16'h8081);
		chk({cmd_fail_r, 8'(n_int)}, 16'h0001, "wake int");
		fr(16'h00c6);
		fr(16'h0084);
		fails(16'h4081, 1, "no wake");
		chk(mq, 3'h6, "restart");
		fr(16'h2082);
		fr(16'h0187);
		fails(16'h4081, 1, "meas wake");
		sbc_mode = 3'h6;
		fr(16'ha584);
		chk(n_wr, 0, "restart ign");
		sbc_mode = 3'h1;
		fn(16'h8081, 15);
		chk(n_md, 0, "short ign");
		fr(16'h0002);
		chk({err, 8'(n_md)}, 16'h0100, "count err");
		fn(16'h0002, 0);
		fn(16'h0002, 0);
		chk(err, 0, "zero clk");
		reset_output_low = 1'b1;
		fr(16'h0002);
		chk(rsp, 16'hffff, "ro high");
		reset_output_low = 1'b0;
		fr(16'h0002);
		chk(err, 1, "ro err");
		finish_test();
	end
endmodule : testbench
